// *** src/ntsc_pkg.sv ***
// register map, field positions and reset values of the oscillator and sync control block
// assumes byte-wide register port with 8-bit addresses
package ntsc_pkg;
   localparam logic [7:0] ADDR_MASTER = 8'h3A;
   localparam logic [7:0] ADDR_OSC_CTRL = 8'h51;
   localparam logic [7:0] ADDR_FREQ3 = 8'h52;
   localparam logic [7:0] ADDR_FREQ2 = 8'h53;
   localparam logic [7:0] ADDR_FREQ1 = 8'h54;
   localparam logic [7:0] ADDR_FREQ0 = 8'h55;
   localparam logic [7:0] ADDR_PHASE_HI = 8'h56;
   localparam logic [7:0] ADDR_PHASE_LO = 8'h57;
   localparam logic [7:0] ADDR_GATE = 8'h58;
   localparam logic [7:0] ADDR_PIN = 8'h59;
   localparam logic [7:0] ADDR_PATH = 8'h5A;

   localparam int MSTR_EN_BIT = 0;
   localparam int OC_QTIE_BIT = 6;
   localparam int OC_REV_BIT = 5;
   localparam int OC_AMP_BIT = 2;
   localparam int OC_PHD_BIT = 1;
   localparam int GC_QNEXT_BIT = 7;
   localparam int GC_QEN_BIT = 6;
   localparam int GC_FNEXT_BIT = 5;
   localparam int GC_FEN_BIT = 4;
   localparam int GC_TNEXT_BIT = 1;
   localparam int GC_TEN_BIT = 0;
   localparam int PS_EDGE_BIT = 1;
   localparam int PS_RISE_BIT = 0;
   localparam int LL_SEL_BIT = 0;

   localparam logic [7:0] MASTER_WMASK = 8'h01;
   localparam logic [7:0] OSC_WMASK = 8'h66;
   localparam logic [7:0] OSC_ONES = 8'h11;
   localparam logic [7:0] GATE_WMASK = 8'hF3;
   localparam logic [7:0] PIN_WMASK = 8'h03;
   localparam logic [7:0] PATH_WMASK = 8'h01;

   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_PATH = 8'h01;
   localparam logic [15:0] DITHER_SEED = 16'hACE1;
   localparam logic [15:0] DITHER_TAPS = 16'hB400;
   localparam int PHD_BITS = 2;
endpackage

// *** src/ntsc_sync_detect.sv ***
// sync pin synchroniser with level or edge detection
// assumes sync_pin is asynchronous to ref_clk
`timescale 1ns/1ps
module ntsc_sync_detect (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic sync_pin,
   input wire logic edge_mode,
   input wire logic rise_sel,
   output logic sync_event
);
   logic meta_q;
   logic sync_s_q;
   logic sync_d_q;
   logic event_q;
   wire rise_w = sync_s_q & ~sync_d_q;
   wire fall_w = ~sync_s_q & sync_d_q;
   wire edge_w = rise_sel ? rise_w : fall_w;
   wire event_d = edge_mode ? edge_w : sync_s_q;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         meta_q <= 1'b0;
         sync_s_q <= 1'b0;
         sync_d_q <= 1'b0;
         event_q <= 1'b0;
      end else begin
         meta_q <= sync_pin;
         sync_s_q <= meta_q;
         sync_d_q <= sync_s_q;
         event_q <= event_d;
      end
   end
   assign sync_event = event_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_level_follow: assert property (!edge_mode |=> sync_event == $past(sync_s_q))
      else $error("level mode event does not follow pin");
   chk_edge_pick: assert property (edge_mode && rise_sel && fall_w |=> !sync_event)
      else $error("falling edge fired in rising mode");
endmodule

// *** src/ntsc_phase_osc.sv ***
// tunable phase accumulator with start phase load and dither
// assumes sample_en is a one-cycle enable at the divided sample rate
`timescale 1ns/1ps
module ntsc_phase_osc #(
   parameter int ACC_W = 32,
   parameter int PH_W = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic sample_en,
   input wire logic [ACC_W-1:0] tuning_word,
   input wire logic [PH_W-1:0] start_phase_word,
   input wire logic reverse,
   input wire logic amp_dither_en,
   input wire logic phase_dither_en,
   input wire logic resync,
   output logic [ACC_W-1:0] acc,
   output logic [PH_W-1:0] phase,
   output logic amp_dither
);
   logic [ACC_W-1:0] acc_q;
   logic [PH_W-1:0] phase_q;
   logic amp_q;
   logic started_q;
   logic [15:0] lfsr_q;
   wire [ACC_W-1:0] step_w = reverse ? (~tuning_word + 1'b1) : tuning_word;
   wire load_w = resync | ~started_q;
   wire [ACC_W-1:0] start_w = {start_phase_word, {(ACC_W-PH_W){1'b0}}};
   wire [ACC_W-1:0] acc_d = load_w ? start_w : (sample_en ? acc_q + step_w : acc_q);
   wire [PH_W-1:0] pdith_w = phase_dither_en ? PH_W'(lfsr_q[ntsc_pkg::PHD_BITS-1:0]) : '0;
   wire [15:0] lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ ntsc_pkg::DITHER_TAPS) : (lfsr_q >> 1);

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         acc_q <= '0;
         phase_q <= '0;
         amp_q <= 1'b0;
         started_q <= 1'b0;
         lfsr_q <= ntsc_pkg::DITHER_SEED;
      end else begin
         acc_q <= acc_d;
         started_q <= 1'b1;
         if (sample_en) begin
            lfsr_q <= lfsr_d;
            phase_q <= acc_q[ACC_W-1 -: PH_W] + pdith_w;
            amp_q <= amp_dither_en & lfsr_q[15];
         end
      end
   end
   assign acc = acc_q;
   assign phase = phase_q;
   assign amp_dither = amp_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_acc_step: assert property (sample_en && !load_w |=> acc_q == $past(acc_q) + $past(step_w))
      else $error("accumulator did not advance by tuning word");
   chk_amp_off: assert property (!amp_dither_en && sample_en |=> !amp_dither)
      else $error("amplitude dither active while disabled");
   chk_phase_nodith: assert property (!phase_dither_en && sample_en && !load_w
         |=> phase == $past(acc_q[ACC_W-1 -: PH_W]))
      else $error("phase dither active while disabled");
endmodule

// *** src/ntsc_top.sv ***
// oscillator tuning, dither and sync gating control with byte register port
// assumes register port and sample_en on ref_clk; sync_pin asynchronous
`timescale 1ns/1ps
module ntsc_top (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic sample_en,
   input wire logic sync_pin,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic [31:0] osc_acc,
   output logic [15:0] osc_phase,
   output logic amp_dither,
   output logic spectral_invert,
   output logic phase_dither_on,
   output logic low_latency_sel,
   output logic quarter_tie_en,
   output logic tunable_sync,
   output logic quarter_sync,
   output logic fir_sync
);
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] t);
      addr_hit = (a == t);
   endfunction

   logic [7:0] master_q;
   logic [7:0] osc_ctrl_q;
   logic [31:0] tuning_word_q;
   logic [15:0] start_phase_word_q;
   logic [7:0] gate_q;
   logic [7:0] gate_d;
   logic [7:0] pin_q;
   logic [7:0] path_q;
   logic [7:0] rdata_q;
   logic tsync_q;
   logic qsync_q;
   logic fsync_q;
   logic rev_q;
   logic phd_q;
   logic ll_q;
   logic qtie_q;
   logic sync_event;

   wire wr_master = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_MASTER);
   wire wr_osc = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_OSC_CTRL);
   wire wr_f3 = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_FREQ3);
   wire wr_f2 = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_FREQ2);
   wire wr_f1 = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_FREQ1);
   wire wr_f0 = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_FREQ0);
   wire wr_ph = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_PHASE_HI);
   wire wr_pl = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_PHASE_LO);
   wire wr_gate = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_GATE);
   wire wr_pin = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_PIN);
   wire wr_path = reg_wr_en && addr_hit(reg_addr, ntsc_pkg::ADDR_PATH);

   wire master_on = master_q[ntsc_pkg::MSTR_EN_BIT];
   wire ev_ok = sync_event & master_on;
   wire t_hit = ev_ok & gate_q[ntsc_pkg::GC_TEN_BIT];
   wire q_hit = ev_ok & gate_q[ntsc_pkg::GC_QEN_BIT];
   wire f_hit = ev_ok & gate_q[ntsc_pkg::GC_FEN_BIT];
   wire t_clr = t_hit & gate_q[ntsc_pkg::GC_TNEXT_BIT];
   wire q_clr = q_hit & gate_q[ntsc_pkg::GC_QNEXT_BIT];
   wire f_clr = f_hit & gate_q[ntsc_pkg::GC_FNEXT_BIT];

   // software write takes priority over the one-shot clear
   always_comb begin
      gate_d = gate_q;
      if (wr_gate) begin
         gate_d = reg_wdata & ntsc_pkg::GATE_WMASK;
      end else begin
         if (t_clr) gate_d[ntsc_pkg::GC_TEN_BIT] = 1'b0;
         if (q_clr) gate_d[ntsc_pkg::GC_QEN_BIT] = 1'b0;
         if (f_clr) gate_d[ntsc_pkg::GC_FEN_BIT] = 1'b0;
      end
   end

   wire [7:0] rd_val =
      addr_hit(reg_addr, ntsc_pkg::ADDR_MASTER) ? master_q :
      addr_hit(reg_addr, ntsc_pkg::ADDR_OSC_CTRL) ? (osc_ctrl_q | ntsc_pkg::OSC_ONES) :
      addr_hit(reg_addr, ntsc_pkg::ADDR_FREQ3) ? tuning_word_q[31:24] :
      addr_hit(reg_addr, ntsc_pkg::ADDR_FREQ2) ? tuning_word_q[23:16] :
      addr_hit(reg_addr, ntsc_pkg::ADDR_FREQ1) ? tuning_word_q[15:8] :
      addr_hit(reg_addr, ntsc_pkg::ADDR_FREQ0) ? tuning_word_q[7:0] :
      addr_hit(reg_addr, ntsc_pkg::ADDR_PHASE_HI) ? start_phase_word_q[15:8] :
      addr_hit(reg_addr, ntsc_pkg::ADDR_PHASE_LO) ? start_phase_word_q[7:0] :
      addr_hit(reg_addr, ntsc_pkg::ADDR_GATE) ? gate_q :
      addr_hit(reg_addr, ntsc_pkg::ADDR_PIN) ? pin_q :
      addr_hit(reg_addr, ntsc_pkg::ADDR_PATH) ? path_q : ntsc_pkg::RST_ZERO;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         master_q <= ntsc_pkg::RST_ZERO;
         osc_ctrl_q <= ntsc_pkg::RST_ZERO;
         tuning_word_q <= '0;
         start_phase_word_q <= '0;
         gate_q <= ntsc_pkg::RST_ZERO;
         pin_q <= ntsc_pkg::RST_ZERO;
         path_q <= ntsc_pkg::RST_PATH;
      end else begin
         if (wr_master) master_q <= reg_wdata & ntsc_pkg::MASTER_WMASK;
         if (wr_osc) osc_ctrl_q <= reg_wdata & ntsc_pkg::OSC_WMASK;
         if (wr_f3) tuning_word_q[31:24] <= reg_wdata;
         if (wr_f2) tuning_word_q[23:16] <= reg_wdata;
         if (wr_f1) tuning_word_q[15:8] <= reg_wdata;
         if (wr_f0) tuning_word_q[7:0] <= reg_wdata;
         if (wr_ph) start_phase_word_q[15:8] <= reg_wdata;
         if (wr_pl) start_phase_word_q[7:0] <= reg_wdata;
         if (wr_pin) pin_q <= reg_wdata & ntsc_pkg::PIN_WMASK;
         if (wr_path) path_q <= reg_wdata & ntsc_pkg::PATH_WMASK;
         gate_q <= gate_d;
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rdata_q <= ntsc_pkg::RST_ZERO;
         tsync_q <= 1'b0;
         qsync_q <= 1'b0;
         fsync_q <= 1'b0;
         rev_q <= 1'b0;
         phd_q <= 1'b0;
         ll_q <= 1'b1;
         qtie_q <= 1'b0;
      end else begin
         if (reg_rd_en) rdata_q <= rd_val;
         tsync_q <= t_hit;
         qsync_q <= q_hit;
         fsync_q <= f_hit;
         rev_q <= osc_ctrl_q[ntsc_pkg::OC_REV_BIT];
         phd_q <= osc_ctrl_q[ntsc_pkg::OC_PHD_BIT];
         ll_q <= path_q[ntsc_pkg::LL_SEL_BIT];
         qtie_q <= osc_ctrl_q[ntsc_pkg::OC_QTIE_BIT];
      end
   end

   assign reg_rdata = rdata_q;
   assign tunable_sync = tsync_q;
   assign quarter_sync = qsync_q;
   assign fir_sync = fsync_q;
   assign spectral_invert = rev_q;
   assign phase_dither_on = phd_q;
   assign low_latency_sel = ll_q;
   assign quarter_tie_en = qtie_q;

   ntsc_sync_detect u_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .sync_pin(sync_pin),
      .edge_mode(pin_q[ntsc_pkg::PS_EDGE_BIT]),
      .rise_sel(pin_q[ntsc_pkg::PS_RISE_BIT]),
      .sync_event(sync_event)
   );

   ntsc_phase_osc #(.ACC_W(32), .PH_W(16)) u_osc (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .sample_en(sample_en),
      .tuning_word(tuning_word_q),
      .start_phase_word(start_phase_word_q),
      .reverse(osc_ctrl_q[ntsc_pkg::OC_REV_BIT]),
      .amp_dither_en(osc_ctrl_q[ntsc_pkg::OC_AMP_BIT]),
      .phase_dither_en(osc_ctrl_q[ntsc_pkg::OC_PHD_BIT]),
      .resync(t_hit),
      .acc(osc_acc),
      .phase(osc_phase),
      .amp_dither(amp_dither)
   );

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_tunable_oneshot;
      t_hit && gate_q[ntsc_pkg::GC_TNEXT_BIT] && !wr_gate;
   endsequence
   sequence s_quarter_oneshot;
      q_hit && gate_q[ntsc_pkg::GC_QNEXT_BIT] && !wr_gate;
   endsequence
   sequence s_fir_oneshot;
      f_hit && gate_q[ntsc_pkg::GC_FNEXT_BIT] && !wr_gate;
   endsequence

   chk_master_gate: assert property (!master_on && !wr_master
         |=> !tunable_sync && !quarter_sync && !fir_sync)
      else $error("sync passed with master enable low");
   chk_tunable_oneshot: assert property (s_tunable_oneshot
         |=> !gate_q[ntsc_pkg::GC_TEN_BIT] && tunable_sync)
      else $error("tunable one-shot did not clear enable");
   chk_quarter_oneshot: assert property (s_quarter_oneshot
         |=> !gate_q[ntsc_pkg::GC_QEN_BIT] && quarter_sync)
      else $error("quarter-rate one-shot did not clear enable");
   chk_fir_oneshot: assert property (s_fir_oneshot
         |=> !gate_q[ntsc_pkg::GC_FEN_BIT] && fir_sync)
      else $error("filter one-shot did not clear enable");
   chk_continuous_keep: assert property (t_hit && !gate_q[ntsc_pkg::GC_TNEXT_BIT] && !wr_gate
         |=> gate_q[ntsc_pkg::GC_TEN_BIT])
      else $error("continuous tunable sync lost its enable");
   chk_quarter_pass: assert property (sync_event && master_on && gate_q[ntsc_pkg::GC_QEN_BIT]
         |=> quarter_sync)
      else $error("quarter-rate sync not passed");
   chk_fir_pass: assert property (sync_event && master_on && gate_q[ntsc_pkg::GC_FEN_BIT]
         |=> fir_sync)
      else $error("filter sync not passed");
   chk_reserved_ones: assert property (reg_rd_en && addr_hit(reg_addr, ntsc_pkg::ADDR_OSC_CTRL)
         |=> reg_rdata[4] && reg_rdata[0])
      else $error("reserved control bits not read as one");
   chk_freq_order: assert property (wr_f3 |=> tuning_word_q[31:24] == $past(reg_wdata))
      else $error("high tuning byte not at lowest address");
   chk_phase_load: assert property (tunable_sync |-> osc_acc == {$past(start_phase_word_q), 16'h0000})
      else $error("start phase not loaded on tunable sync");
   chk_reversal_out: assert property ($rose(osc_ctrl_q[ntsc_pkg::OC_REV_BIT])
         |=> spectral_invert ##1 spectral_invert || $past(wr_osc))
      else $error("spectral reversal output did not follow bit");
endmodule

// *** dv/ntsc_sync_source.sv ***
// sync strobe source standing in front of the sync pin
// assumes ref_clk only paces strobes; pin edges land 3 ns off the clock edge
`timescale 1ns/1ps
module ntsc_sync_source (
   input wire logic ref_clk,
   output logic sync_pin
);
   // idle low between strobes
   initial sync_pin = 1'b0;

   // high for hi clock periods, then low for lo periods
   task automatic strobe(input int hi, input int lo);
      @(posedge ref_clk);
      #3 sync_pin = 1'b1;
      repeat (hi) @(posedge ref_clk);
      #3 sync_pin = 1'b0;
      repeat (lo) @(posedge ref_clk);
   endtask
endmodule

// *** dv/ntsc_top_test.sv ***
// self-checking bench for the oscillator tuning and sync gating block
// assumes the sync source model drives the pin; all else driven here
`timescale 1ns/1ps
module ntsc_top_test;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic sample_en = 1'b0;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic sync_pin;
   logic [7:0] reg_rdata;
   logic [31:0] osc_acc;
   logic [15:0] osc_phase;
   logic amp_dither, spectral_invert, phase_dither_on, low_latency_sel, quarter_tie_en;
   logic tunable_sync, quarter_sync, fir_sync;
   int num_errors = 0;
   int total_checks = 0;
   int cnt;
   logic [7:0] rd_q[$];
   logic [18:0] sy_q[$];
   logic [18:0] ent;
   logic [15:0] rnd_s = 16'hE610;
   logic [15:0] se_s = 16'hE610;
   logic [15:0] ph_exp = 16'h0000;
   logic [31:0] tw_exp = 32'h0000_0000;
   logic [31:0] acc_m = 32'h0000_0000;
   logic rev_exp = 1'b0;
   logic acc_arm = 1'b0;
   logic acc_on = 1'b0;
   logic rd_d = 1'b0;
   logic amp_prev = 1'b0;
   logic [15:0] ph_m = 16'h0000;
   logic ph_v = 1'b0;
   logic [7:0] amap[12] = '{8'h3A, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
                            8'h58, 8'h59, 8'h5A, 8'h50};
   logic [7:0] rst_v[12] = '{8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h01, 8'h00};
   logic [7:0] ful_v[12] = '{8'h01, 8'h77, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                             8'hF3, 8'h03, 8'h01, 8'h00};
   wire [31:0] weff = rev_exp ? -tw_exp : tw_exp;

   always #4 ref_clk = ~ref_clk;

   ntsc_top u_ntsc_top (.ref_clk(ref_clk), .resetn(resetn), .sample_en(sample_en),
      .sync_pin(sync_pin), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .osc_acc(osc_acc), .osc_phase(osc_phase), .amp_dither(amp_dither),
      .spectral_invert(spectral_invert), .phase_dither_on(phase_dither_on),
      .low_latency_sel(low_latency_sel), .quarter_tie_en(quarter_tie_en),
      .tunable_sync(tunable_sync), .quarter_sync(quarter_sync), .fir_sync(fir_sync));
   ntsc_sync_source u_ntsc_sync_source (.ref_clk(ref_clk), .sync_pin(sync_pin));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function logic [15:0] rnd();
      rnd_s = lfsr(rnd_s);
      return rnd_s;
   endfunction

   // random sample enables, drawn afresh each cycle from two LFSR bits; may stay high for consecutive cycles
   always @(posedge ref_clk) begin
      se_s <= lfsr(se_s);
      sample_en <= se_s[0] & se_s[3];
   end

   task automatic miss(input logic [31:0] e, input logic [31:0] g);
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
   endtask
   task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) miss(32'(e), 32'(g));
   endtask
   task automatic cmp_sync(input logic [2:0] e, input logic [2:0] g);
      total_checks++;
      if (g !== e) miss(32'(e), 32'(g));
   endtask
   task automatic cmp_acc(input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) miss(e, g);
   endtask
   task automatic cmp_flag(input logic e, input logic g);
      total_checks++;
      if (g !== e) miss(32'(e), 32'(g));
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      rd_q.push_back(e);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
   endtask
   task automatic wr_phase();
      ph_exp = rnd();
      wr(ntsc_pkg::ADDR_PHASE_HI, ph_exp[15:8]);
      wr(ntsc_pkg::ADDR_PHASE_LO, ph_exp[7:0]);
   endtask
   task automatic wr_word(input logic [31:0] w);
      tw_exp = w;
      for (int i = 0; i < 4; i++) wr(8'(ntsc_pkg::ADDR_FREQ3 + i), w[31-8*i -: 8]);
   endtask

   // results monitor: read data, sync pulses, accumulator walk
   always @(posedge ref_clk) begin
      if (rd_d) begin
         if (rd_q.size() == 0) miss(32'h0, 32'(reg_rdata));
         else cmp_reg(rd_q.pop_front(), reg_rdata);
      end
      rd_d = reg_rd_en;
      if (resetn && (tunable_sync || quarter_sync || fir_sync)) begin
         if (sy_q.size() == 0) miss(32'h0, {29'h0, tunable_sync, quarter_sync, fir_sync});
         else begin
            ent = sy_q.pop_front();
            cmp_sync(ent[18:16], {tunable_sync, quarter_sync, fir_sync});
            if (tunable_sync) cmp_acc({ent[15:0], 16'h0000}, osc_acc);
         end
      end
      if (acc_on) begin
         cmp_acc(acc_m, osc_acc);
         if (ph_v) cmp_acc(32'(ph_m), 32'(osc_phase));
         if (sample_en) begin
            ph_m = acc_m[31:16];
            ph_v = 1'b1;
            acc_m = acc_m + weff;
         end
      end else if (acc_arm && tunable_sync) begin
         acc_on = 1'b1;
         ph_v = 1'b0;
         acc_m = {ph_exp, 16'h0000} + (sample_en ? weff : 32'h0);
      end
   end

   task automatic sync_case(input logic [7:0] m, input logic [7:0] g, input logic [7:0] p,
                            input int hi, input int n, input logic [2:0] e1,
                            input logic [2:0] e2, input logic [7:0] g_after);
      wr(ntsc_pkg::ADDR_MASTER, m);
      wr(ntsc_pkg::ADDR_GATE, g);
      wr(ntsc_pkg::ADDR_PIN, p);
      wr_phase();
      for (int k = 0; k < n; k++) begin
         for (int j = 0; j < (p[1] ? 1 : hi); j++) begin
            if ((k == 0 ? e1 : e2) != 3'b000) sy_q.push_back({(k == 0 ? e1 : e2), ph_exp});
         end
         u_ntsc_sync_source.strobe(hi, 8);
      end
      repeat (6) @(posedge ref_clk);
      cmp_reg(8'h00, 8'(sy_q.size()));
      rd(ntsc_pkg::ADDR_GATE, g_after);
      $display("sync case gate=%h pin=%h done", g, p);
   endtask

   task automatic acc_case(input logic rev);
      wr(ntsc_pkg::ADDR_OSC_CTRL, rev ? 8'h20 : 8'h00);
      rev_exp = rev;
      wr_word({rnd(), rnd()});
      wr(ntsc_pkg::ADDR_GATE, 8'h01);
      wr(ntsc_pkg::ADDR_PIN, 8'h03);
      wr_phase();
      sy_q.push_back({3'b100, ph_exp});
      acc_arm = 1'b1;
      u_ntsc_sync_source.strobe(2, 60);
      acc_arm = 1'b0;
      acc_on = 1'b0;
      $display("accumulator case reverse=%0d done", rev);
   endtask

   task automatic summarize();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      summarize();
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      cmp_acc(32'h0, osc_acc);
      cmp_flag(1'b1, low_latency_sel);
      for (int i = 0; i < 12; i++) rd(amap[i], rst_v[i]);
      for (int i = 0; i < 12; i++) wr(amap[i], 8'hFF);
      for (int i = 0; i < 12; i++) rd(amap[i], ful_v[i]);
      cmp_flag(1'b1, spectral_invert);
      cmp_flag(1'b1, phase_dither_on);
      cmp_flag(1'b1, quarter_tie_en);
      for (int i = 0; i < 12; i++) wr(amap[i], 8'h00);
      repeat (2) @(posedge ref_clk);
      cmp_flag(1'b0, spectral_invert);
      cmp_flag(1'b0, phase_dither_on);
      cmp_flag(1'b0, low_latency_sel);
      $display("register case done");
      sync_case(8'h00, 8'h51, 8'h00, 3, 1, 3'b000, 3'b000, 8'h51);
      sync_case(8'h01, 8'h51, 8'h00, 3, 1, 3'b111, 3'b000, 8'h51);
      sync_case(8'h01, 8'h51, 8'h03, 2, 2, 3'b111, 3'b111, 8'h51);
      sync_case(8'h01, 8'h51, 8'h02, 2, 1, 3'b111, 3'b000, 8'h51);
      sync_case(8'h01, 8'hF3, 8'h03, 2, 2, 3'b111, 3'b000, 8'hA2);
      sync_case(8'h01, 8'hC1, 8'h03, 2, 2, 3'b110, 3'b100, 8'h81);
      acc_case(1'b0);
      acc_case(1'b1);
      wr(ntsc_pkg::ADDR_OSC_CTRL, 8'h04);
      cnt = 0;
      amp_prev = amp_dither;
      repeat (80) begin
         @(posedge ref_clk);
         if (amp_dither !== amp_prev) cnt++;
         amp_prev = amp_dither;
      end
      cmp_flag(1'b1, cnt > 0);
      wr(ntsc_pkg::ADDR_OSC_CTRL, 8'h00);
      repeat (3) @(posedge ref_clk);
      cnt = 0;
      repeat (40) @(posedge ref_clk) cnt += (amp_dither !== 1'b0) ? 1 : 0;
      cmp_reg(8'h00, 8'(cnt));
      $display("dither case done");
      wr(ntsc_pkg::ADDR_PATH, 8'h01);
      wr_word(32'h4000_0000);
      wr(ntsc_pkg::ADDR_OSC_CTRL, 8'h40);
      repeat (2) @(posedge ref_clk);
      cmp_flag(1'b1, low_latency_sel);
      cmp_flag(1'b1, quarter_tie_en);
      $display("low latency case done");
      summarize();
   end
endmodule
